// *** gpd_dev_if.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Source handshake sends each byte correctly
// - Acceptor handshake takes each command byte, and data bytes while addressed to listen
// - Talk when addressed to talk
// - Listen when addressed to listen
// - Device clear restores power-on settings
// - Trigger applies held values
// - Trigger in local waits for remote
// - Poll response follows status bit 7
// - Parallel poll keeps service request
// - Configure poll sense and line remotely
// - Switch between front panel and remote
// - Raise service request when condition arises
// - Serial poll returns one status byte
// - Addressed lamp while listener or talker
// - Lockout ignores front panel local request
// - Lockout ends only when remote enable drops
// - Go-to-local works even under lockout
// - Output off on each local-to-remote
// - Serial poll clears service request bit
module gpd_dev_if (
  input  wire logic               clk,        // 40 MHz system clock
  input  wire logic               rst_b,      // reset, active low
  input  wire gpd_pkg::gpd_lines_t busIn,     // raw bus levels, low true
  output      gpd_pkg::gpd_lines_t busOut,    // level driven, always low
  output      gpd_pkg::gpd_lines_t busOe,     // pull line low when set
  input  wire logic [4:0]         myAddr,     // primary bus address
  input  wire logic               localReq,   // front panel local key
  input  wire logic               svcReq,     // enabled service condition
  input  wire logic [5:0]         statusIn,   // low status byte bits
  input  wire logic [7:0]         txData,     // byte to talk
  input  wire logic               txEoi,      // byte is last
  input  wire logic               txValid,    // txData is ready
  input  wire logic               outOnCmd,   // pulse, output on
  input  wire logic               outOffCmd,  // pulse, output off
  output      logic               txTaken,    // pulse, tx byte sent
  output      logic [7:0]         rxData,     // listened byte
  output      logic               rxEoi,      // byte came with end
  output      logic               rxValid,    // pulse, rxData new
  output      logic               remoteMode, // remote control active
  output      logic               lockout,    // local lockout active
  output      logic               addressed,  // addressed lamp
  output      logic               outputOn,   // supply output enable
  output      logic               trigger,    // pulse, apply held values
  output      logic               devClear    // pulse, restore settings
);

  logic [1:0] rstPipe;
  logic       rstB;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) rstPipe <= 2'h0;
    else        rstPipe <= {rstPipe[0], 1'h1};
  end
  assign rstB = rstPipe[1];

  logic [gpd_pkg::SYNC_W-1:0] syncQ;
  gpd_pkg::gpd_lines_t        ln;
  logic                       locS;

  gpd_sync #(
    .W       (gpd_pkg::SYNC_W),
    .RST_VAL (gpd_pkg::SYNC_RST)
  ) u_sync (
    .clk  (clk),
    .rstB (rstB),
    .d    ({busIn, localReq}),
    .q    (syncQ)
  );

  // Bus lines are low true
  assign ln   = ~syncQ[gpd_pkg::SYNC_W-1:1];
  assign locS = syncQ[0];

  gpd_pkg::gpd_dev_st_t st_q;
  gpd_pkg::gpd_dev_st_t st_d;

  logic       byteIn;
  logic       cmdIn;
  logic       dataIn;
  logic [6:0] cmd;
  logic       isMla;
  logic       isMta;
  logic       isOta;
  logic       isSec;
  logic       svcRise;
  logic       ppActive;
  logic       ppDrive;
  logic       talkAct;
  logic       srcStart;
  logic       srcDone;
  logic       srcDav;
  logic       srcEoi;
  logic [7:0] srcData;
  logic       spRead;
  logic [7:0] statusByte;

  assign byteIn   = (st_q.ah == gpd_pkg::AH_READY) && ln.dav;
  assign cmdIn    = byteIn && ln.atn;
  assign dataIn   = byteIn && !ln.atn && st_q.lAddr;
  assign cmd      = ln.dio[6:0];
  assign isMla    = cmd == {gpd_pkg::GRP_LISTEN, myAddr};
  assign isMta    = cmd == {gpd_pkg::GRP_TALK, myAddr};
  assign isOta    = cmd[6:5] == gpd_pkg::GRP_TALK && !isMta;
  assign isSec    = cmd[6:5] == gpd_pkg::GRP_SEC;
  assign svcRise  = svcReq && !st_q.svcPrev;
  assign ppActive = ln.atn && ln.eoi;
  assign talkAct  = st_q.tAddr && !ln.atn;
  assign statusByte = {st_q.pon, st_q.rqs, statusIn[gpd_pkg::STAT_USR-1:0]};
  assign ppDrive  = st_q.ppEn &&
                    statusByte[gpd_pkg::STAT_PON] == st_q.ppSense;
  assign srcStart = talkAct &&
                    (st_q.spMode ? !st_q.spSent : txValid);
  assign spRead   = srcDone && st_q.spMode;

  // Serial poll sends the status byte with end, once
  gpd_src_hs u_src (
    .clk     (clk),
    .rstB    (rstB),
    .start   (srcStart),
    .abort   (!talkAct),
    .dataIn  (st_q.spMode ? statusByte : txData),
    .eoiIn   (st_q.spMode || txEoi),
    .nrfd    (ln.nrfd),
    .ndac    (ln.ndac),
    .dav     (srcDav),
    .dataOut (srcData),
    .eoiOut  (srcEoi),
    .done    (srcDone)
  );

  always_comb begin
    st_d = st_q;
    st_d.trigger = 1'b0;
    st_d.devClr  = 1'b0;
    st_d.rxValid = 1'b0;
    st_d.svcPrev = svcReq;

    unique case (st_q.ah)
      gpd_pkg::AH_IDLE:
        if (ln.atn || st_q.lAddr) st_d.ah = gpd_pkg::AH_READY;
      gpd_pkg::AH_READY:
        if (!(ln.atn || st_q.lAddr)) st_d.ah = gpd_pkg::AH_IDLE;
        else if (ln.dav) st_d.ah = gpd_pkg::AH_TAKE;
      gpd_pkg::AH_TAKE:
        if (!ln.dav) st_d.ah = gpd_pkg::AH_READY;
    endcase

    if (dataIn) begin
      st_d.rxData  = ln.dio;
      st_d.rxEoi   = ln.eoi;
      st_d.rxValid = 1'b1;
    end

    if (cmdIn) begin
      if (!isSec) st_d.ppcArmed = 1'b0;
      if (cmd == gpd_pkg::CMD_UNL) st_d.lAddr = 1'b0;
      if (cmd == gpd_pkg::CMD_UNT || isOta) st_d.tAddr = 1'b0;
      if (isMla) begin
        st_d.lAddr = 1'b1;
        if (ln.ren) st_d.remote = 1'b1;
      end
      if (isMta) st_d.tAddr = 1'b1;
      if (cmd == gpd_pkg::CMD_LLO && ln.ren) st_d.llo = 1'b1;
      if (cmd == gpd_pkg::CMD_GTL && st_q.lAddr) st_d.remote = 1'b0;
      if (cmd == gpd_pkg::CMD_DCL ||
          (cmd == gpd_pkg::CMD_SDC && st_q.lAddr)) begin
        st_d.devClr = 1'b1;
        st_d.outOn  = gpd_pkg::OUT_RST;
        st_d.pon    = 1'b0;
      end
      if (cmd == gpd_pkg::CMD_GET && st_q.lAddr) begin
        if (st_q.remote) st_d.trigger = 1'b1;
        else st_d.pendTrig = 1'b1;
      end
      if (cmd == gpd_pkg::CMD_SPE) begin
        st_d.spMode = 1'b1;
        st_d.spSent = 1'b0;
      end
      if (cmd == gpd_pkg::CMD_SPD) st_d.spMode = 1'b0;
      if (cmd == gpd_pkg::CMD_PPC && st_q.lAddr) st_d.ppcArmed = 1'b1;
      if (cmd == gpd_pkg::CMD_PPU) st_d.ppEn = 1'b0;
      if (isSec && st_q.ppcArmed) begin
        st_d.ppEn    = !cmd[gpd_pkg::SEC_DIS_BIT];
        st_d.ppSense = cmd[gpd_pkg::SEC_SENSE_BIT];
        st_d.ppLine  = cmd[2:0];
      end
    end

    if (locS && !st_q.llo) st_d.remote = 1'b0;
    if (!ln.ren) begin
      st_d.remote = 1'b0;
      st_d.llo    = 1'b0;
    end
    if (ln.ifc) begin
      st_d.lAddr    = 1'b0;
      st_d.tAddr    = 1'b0;
      st_d.spMode   = 1'b0;
      st_d.ppcArmed = 1'b0;
    end

    if (outOnCmd) st_d.outOn = 1'b1;
    if (outOffCmd && !st_d.devClr) st_d.outOn = 1'b0;
    if (st_d.remote && !st_q.remote) begin
      st_d.outOn = 1'b0;
      if (st_d.pendTrig) begin
        st_d.trigger  = 1'b1;
        st_d.pendTrig = 1'b0;
      end
    end

    // Poll read clears, new condition wins, parallel poll untouched
    if (spRead) begin
      st_d.rqs    = 1'b0;
      st_d.spSent = 1'b1;
    end
    if (svcRise) st_d.rqs = 1'b1;
    st_d.txTaken = srcDone && !st_q.spMode;

    st_d.addressed = st_d.lAddr || st_d.tAddr;
    st_d.oe      = '0;
    st_d.oe.nrfd = st_d.ah == gpd_pkg::AH_TAKE;
    st_d.oe.ndac = st_d.ah == gpd_pkg::AH_READY;
    st_d.oe.dav  = srcDav;
    st_d.oe.eoi  = srcDav && srcEoi;
    st_d.oe.srq  = st_d.rqs;
    if (ppActive && ppDrive) st_d.oe.dio = 8'(8'h01 << st_q.ppLine);
    else if (talkAct) st_d.oe.dio = srcData;
  end

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) st_q <= gpd_pkg::DEV_RST;
    else       st_q <= st_d;
  end

  assign busOut     = '0;
  assign busOe      = st_q.oe;
  assign txTaken    = st_q.txTaken;
  assign rxData     = st_q.rxData;
  assign rxEoi      = st_q.rxEoi;
  assign rxValid    = st_q.rxValid;
  assign remoteMode = st_q.remote;
  assign lockout    = st_q.llo;
  assign addressed  = st_q.addressed;
  assign outputOn   = st_q.outOn;
  assign trigger    = st_q.trigger;
  assign devClear   = st_q.devClr;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstB);

  ah_take_a: assert property (
    byteIn |=> busOe.nrfd && !busOe.ndac)
    else $error("Acceptor did not hold off after byte");
  srq_raise_a: assert property (
    svcRise |=> ##1 busOe.srq)
    else $error("Service request line not raised");
  pp_keep_a: assert property (
    st_q.rqs && ppActive && !spRead |=> st_q.rqs)
    else $error("Parallel poll cleared service request");
  pp_line_a: assert property (
    ppActive && ppDrive |=> busOe.dio[$past(st_q.ppLine)])
    else $error("Parallel poll line not driven");
  lock_exit_a: assert property (
    $fell(st_q.llo) |-> !$past(ln.ren))
    else $error("Lockout left while remote enable held");
  lock_hold_a: assert property (
    st_q.llo && st_q.remote && ln.ren && locS && !cmdIn |=> st_q.remote)
    else $error("Front panel escaped lockout");
  gtl_local_a: assert property (
    cmdIn && cmd == gpd_pkg::CMD_GTL && st_q.lAddr |=> !st_q.remote)
    else $error("Go to local ignored");
  out_off_a: assert property (
    $rose(st_q.remote) |-> !st_q.outOn)
    else $error("Output left on entering remote");
  trig_defer_a: assert property (
    $rose(st_q.remote) && $past(st_q.pendTrig) |-> st_q.trigger)
    else $error("Deferred trigger not applied");
  trig_now_a: assert property (
    cmdIn && cmd == gpd_pkg::CMD_GET && st_q.lAddr && st_q.remote
    |=> st_q.trigger)
    else $error("Remote trigger not applied");
  dc_init_a: assert property (
    cmdIn && cmd == gpd_pkg::CMD_DCL |=> st_q.devClr && st_q.outOn)
    else $error("Device clear did not restore");
  sp_clear_a: assert property (
    spRead && !svcRise |=> !st_q.rqs)
    else $error("Serial poll left service request set");
  led_on_a: assert property (
    cmdIn && isMla && !ln.ifc |=> addressed)
    else $error("Addressed lamp dark after listen address");
  led_off_a: assert property (
    cmdIn && cmd == gpd_pkg::CMD_UNL && !st_q.tAddr |=> !addressed)
    else $error("Addressed lamp lit after unlisten");
  rx_data_a: assert property (
    dataIn |=> rxValid && rxData == $past(ln.dio))
    else $error("Listened byte not handed on");
  talk_data_a: assert property (
    talkAct |=> busOe.dio == $past(srcData))
    else $error("Talk byte not on data lines");
  panel_local_a: assert property (
    locS && !st_q.llo |=> !st_q.remote)
    else $error("Front panel local key ignored");

  sp_read_c: cover property (spRead);
  pp_drive_c: cover property (ppActive && ppDrive);
  trig_defer_c: cover property ($rose(st_q.remote) && st_q.trigger);
  lock_c: cover property (st_q.llo && locS);

endmodule // gpd_dev_if

// *** gpd_pkg.sv ***
package gpd_pkg;

  // Timing
  localparam int CLK_NS     = 25;
  localparam int SETTLE_NS  = 2000;
  localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] SETTLE_LAST = 7'(SETTLE_CYC - 1);

  // Primary commands, parity bit dropped
  localparam logic [6:0] CMD_GTL = 7'h01;
  localparam logic [6:0] CMD_SDC = 7'h04;
  localparam logic [6:0] CMD_PPC = 7'h05;
  localparam logic [6:0] CMD_GET = 7'h08;
  localparam logic [6:0] CMD_LLO = 7'h11;
  localparam logic [6:0] CMD_DCL = 7'h14;
  localparam logic [6:0] CMD_PPU = 7'h15;
  localparam logic [6:0] CMD_SPE = 7'h18;
  localparam logic [6:0] CMD_SPD = 7'h19;
  localparam logic [6:0] CMD_UNL = 7'h3F;
  localparam logic [6:0] CMD_UNT = 7'h5F;

  // Command groups in bits 6:5
  localparam logic [1:0] GRP_LISTEN = 2'h1;
  localparam logic [1:0] GRP_TALK   = 2'h2;
  localparam logic [1:0] GRP_SEC    = 2'h3;
  localparam int SEC_DIS_BIT   = 4;
  localparam int SEC_SENSE_BIT = 3;

  // Status byte layout
  localparam int STAT_PON = 7;
  localparam int STAT_RQS = 6;
  localparam int STAT_USR = 6;

  localparam logic PON_RST = 1'h1;
  localparam logic OUT_RST = 1'h1;

  // Raw bus lines idle high, front panel request idle low
  localparam int SYNC_W = 17;
  localparam logic [SYNC_W-1:0] SYNC_RST = 17'h1FFFE;

  typedef struct packed {
    logic [7:0] dio;
    logic       dav;
    logic       nrfd;
    logic       ndac;
    logic       eoi;
    logic       srq;
    logic       atn;
    logic       ifc;
    logic       ren;
  } gpd_lines_t;

  typedef enum logic [1:0] {AH_IDLE, AH_READY, AH_TAKE} gpd_ah_t;
  typedef enum logic [1:0] {SH_IDLE, SH_SETTLE, SH_DAV, SH_END} gpd_sh_t;

  typedef struct packed {
    gpd_sh_t    st;
    logic [6:0] cnt;
    logic [7:0] data;
    logic       eoi;
    logic       dav;
    logic       done;
  } gpd_src_st_t;

  typedef struct packed {
    gpd_ah_t    ah;
    logic       lAddr;
    logic       tAddr;
    logic       spMode;
    logic       spSent;
    logic       ppcArmed;
    logic       ppEn;
    logic       ppSense;
    logic [2:0] ppLine;
    logic       remote;
    logic       llo;
    logic       rqs;
    logic       pon;
    logic       pendTrig;
    logic       outOn;
    logic       trigger;
    logic       devClr;
    logic [7:0] rxData;
    logic       rxEoi;
    logic       rxValid;
    logic       txTaken;
    logic       svcPrev;
    logic       addressed;
    gpd_lines_t oe;
  } gpd_dev_st_t;

  localparam gpd_src_st_t SRC_RST = '{st: SH_IDLE, default: '0};
  localparam gpd_dev_st_t DEV_RST =
    '{ah: AH_IDLE, pon: PON_RST, outOn: OUT_RST, default: '0};

endpackage

// *** gpd_sync.sv ***
`timescale 1ns/1ps
module gpd_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         clk,   // system clock
  input  wire logic         rstB,  // reset, active low
  input  wire logic [W-1:0] d,     // asynchronous inputs
  output      logic [W-1:0] q      // synchronised copy
);

  logic [1:0][W-1:0] st_q;
  logic [1:0][W-1:0] st_d;

  always_comb begin
    st_d = {st_q[0], d};
  end

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) st_q <= {RST_VAL, RST_VAL};
    else       st_q <= st_d;
  end

  assign q = st_q[1];

endmodule // gpd_sync

// *** gpd_src_hs.sv ***
`timescale 1ns/1ps
module gpd_src_hs (
  input  wire logic       clk,     // system clock
  input  wire logic       rstB,    // reset, active low
  input  wire logic       start,   // send dataIn when idle
  input  wire logic       abort,   // leave talking, drop DAV
  input  wire logic [7:0] dataIn,  // byte to send
  input  wire logic       eoiIn,   // byte is last
  input  wire logic       nrfd,    // not-ready asserted on bus
  input  wire logic       ndac,    // not-accepted asserted on bus
  output      logic       dav,     // data valid asserted
  output      logic [7:0] dataOut, // byte on the lines
  output      logic       eoiOut,  // end flag for byte
  output      logic       done     // pulse, byte accepted
);

  gpd_pkg::gpd_src_st_t st_q;
  gpd_pkg::gpd_src_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    unique case (st_q.st)
      gpd_pkg::SH_IDLE: if (start && !abort) begin
        st_d.st   = gpd_pkg::SH_SETTLE;
        st_d.cnt  = '0;
        st_d.data = dataIn;
        st_d.eoi  = eoiIn;
      end
      gpd_pkg::SH_SETTLE: begin
        if (st_q.cnt != gpd_pkg::SETTLE_LAST) st_d.cnt = st_q.cnt + 7'h01;
        else if (!nrfd) begin
          st_d.dav = 1'b1;
          st_d.st  = gpd_pkg::SH_DAV;
        end
      end
      gpd_pkg::SH_DAV: if (!ndac) begin
        st_d.dav  = 1'b0;
        st_d.done = 1'b1;
        st_d.st   = gpd_pkg::SH_END;
      end
      gpd_pkg::SH_END: if (ndac) st_d.st = gpd_pkg::SH_IDLE;
    endcase
    if (abort) begin
      st_d.dav = 1'b0;
      st_d.st  = gpd_pkg::SH_IDLE;
    end
  end

  always_ff @(posedge clk or negedge rstB) begin
    if (!rstB) st_q <= gpd_pkg::SRC_RST;
    else       st_q <= st_d;
  end

  assign dav     = st_q.dav;
  assign dataOut = st_q.data;
  assign eoiOut  = st_q.eoi;
  assign done    = st_q.done;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstB);

  dav_after_settle_a: assert property (
    $rose(st_q.dav) |-> $past(st_q.cnt) == gpd_pkg::SETTLE_LAST && !$past(nrfd))
    else $error("DAV raised before settle or while not ready");
  dav_holds_a: assert property (
    st_q.dav && ndac && !abort |=> st_q.dav)
    else $error("DAV dropped before byte accepted");
  src_done_c: cover property (st_q.done);

endmodule // gpd_src_hs

// *** gpd_ctl_model.sv ***
`timescale 1ns/1ps
module gpd_ctl_model (
  input  wire gpd_pkg::gpd_lines_t lvl,  // wire levels, low true
  input  wire logic                clk,  // system clock
  output      gpd_pkg::gpd_lines_t asrt  // lines pulled low here
);
  gpd_pkg::gpd_lines_t a;
  int                  n;

  assign asrt = a;

  initial a = '0;

  task automatic pulseIfc();
    @(posedge clk);
    a.ifc <= 1'b1;
    repeat (8) @(posedge clk);
    a.ifc <= 1'b0;
  endtask

  task automatic setRen(input logic v);
    @(posedge clk);
    a.ren <= v;
  endtask

  // Controller as source; data released only after DAV drops
  task automatic sd(input logic [7:0] b, input logic atn, input logic eoi);
    @(posedge clk);
    a.atn <= atn;
    a.dio <= b;
    a.eoi <= eoi;
    @(posedge clk);
    n = 0;
    while ((!lvl.nrfd || lvl.ndac) && n < 200) begin
      @(posedge clk);
      n++;
    end
    a.dav <= 1'b1;
    n = 0;
    while (!lvl.ndac && n < 200) begin
      @(posedge clk);
      n++;
    end
    a.dav <= 1'b0;
    @(posedge clk);
    a.dio <= '0;
    a.eoi <= 1'b0;
  endtask

  // Controller as acceptor; stall delays the accept
  task automatic rd(output logic [7:0] b, output logic e, input int stall);
    @(posedge clk);
    a.atn  <= 1'b0;
    a.ndac <= 1'b1;
    a.nrfd <= 1'b0;
    n = 0;
    while (lvl.dav && n < 400) begin
      @(posedge clk);
      n++;
    end
    b = ~lvl.dio;
    e = ~lvl.eoi;
    a.nrfd <= 1'b1;
    repeat (stall) @(posedge clk);
    a.ndac <= 1'b0;
    n = 0;
    while (!lvl.dav && n < 400) begin
      @(posedge clk);
      n++;
    end
    a.nrfd <= 1'b0;
  endtask

  task automatic pp(output logic [7:0] r);
    @(posedge clk);
    a.atn <= 1'b1;
    a.eoi <= 1'b1;
    repeat (6) @(posedge clk);
    r = ~lvl.dio;
    a.eoi <= 1'b0;
  endtask
endmodule // gpd_ctl_model

// *** gpd_tb.sv ***
`timescale 1ns/1ps
module testbench;
  localparam logic [4:0] ADR  = 5'h05;
  localparam logic [5:0] STAT = 6'h2A;
  localparam logic [6:0] LA   = {gpd_pkg::GRP_LISTEN, ADR};
  localparam logic [6:0] TA   = {gpd_pkg::GRP_TALK, ADR};
  localparam logic [6:0] MTA0 = {gpd_pkg::GRP_TALK, 5'h00};

  logic                clk      = 1'b0;
  logic                rst_b    = 1'b0;
  logic                localReq = 1'b0;
  logic                svcReq   = 1'b0;
  logic [7:0]          txData   = 8'h00;
  logic                txEoi    = 1'b0;
  logic                txValid  = 1'b0;
  logic                outOnCmd = 1'b0;
  gpd_pkg::gpd_lines_t busOe, busOut, ctl, lvl;
  logic                txTaken, rxEoi, rxValid, remoteMode, lockout;
  logic                addressed, outputOn, trigger, devClear, rxE;
  logic [7:0]          rxData, rxLast, b;
  logic                e;
  int                  nTrig     = 0;
  int                  nClr      = 0;
  int                  nTx       = 0;
  int                  errorCnt  = 0;
  int                  cmpCount  = 0;

  always #12.5 clk = ~clk;

  assign lvl = ~(ctl | busOe);

  gpd_dev_if gpd_dev_if_i (
    .clk(clk), .rst_b(rst_b), .busIn(lvl), .busOut(busOut), .busOe(busOe),
    .myAddr(ADR), .localReq(localReq), .svcReq(svcReq), .statusIn(STAT),
    .txData(txData), .txEoi(txEoi), .txValid(txValid),
    .outOnCmd(outOnCmd), .outOffCmd(1'b0), .txTaken(txTaken),
    .rxData(rxData), .rxEoi(rxEoi), .rxValid(rxValid),
    .remoteMode(remoteMode), .lockout(lockout), .addressed(addressed),
    .outputOn(outputOn), .trigger(trigger), .devClear(devClear)
  );

  gpd_ctl_model gpd_ctl_model_i (.lvl(lvl), .clk(clk), .asrt(ctl));

  always @(posedge clk) begin
    if (trigger) nTrig++;
    if (devClear) nClr++;
    if (rxValid) begin
      rxLast <= rxData;
      rxE    <= rxEoi;
    end
    if (txTaken) nTx++;
  end

  task automatic chk(input string nm, input logic [15:0] got, exp);
    cmpCount++;
    if (got !== exp) begin
      errorCnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cmd(input logic [6:0] c);
    gpd_ctl_model_i.sd({1'b0, c}, 1'b1, 1'b0);
    repeat (6) @(posedge clk);
  endtask

  task automatic key();
    localReq <= 1'b1;
    repeat (4) @(posedge clk);
    localReq <= 1'b0;
    repeat (6) @(posedge clk);
  endtask

  task automatic lloSeq(input logic ren);
    gpd_ctl_model_i.pulseIfc();
    gpd_ctl_model_i.setRen(ren);
    cmd(gpd_pkg::CMD_UNL);
    cmd(gpd_pkg::CMD_UNT);
    cmd(MTA0);
    cmd(gpd_pkg::CMD_LLO);
  endtask

  task automatic tReset();
    chk("remote", 16'(remoteMode), 16'h0000);
    chk("lockout", 16'(lockout), 16'h0000);
    chk("addressed", 16'(addressed), 16'h0000);
    chk("outputOn", 16'(outputOn), 16'h0001);
    chk("busOe", busOe, 16'h0000);
    chk("busOut", busOut, 16'h0000);
    $display("reset test done");
  endtask

  task automatic tListen();
    gpd_ctl_model_i.setRen(1'b1);
    cmd(gpd_pkg::CMD_UNL);
    cmd(LA);
    chk("addressed", 16'(addressed), 16'h0001);
    chk("remote", 16'(remoteMode), 16'h0001);
    chk("outputOn", 16'(outputOn), 16'h0000);
    outOnCmd <= 1'b1;
    @(posedge clk);
    outOnCmd <= 1'b0;
    repeat (3) @(posedge clk);
    chk("outputOn", 16'(outputOn), 16'h0001);
    gpd_ctl_model_i.sd(8'hA5, 1'b0, 1'b1);
    repeat (4) @(posedge clk);
    chk("rxData", 16'(rxLast), 16'h00A5);
    chk("rxEoi", 16'(rxE), 16'h0001);
    cmd(gpd_pkg::CMD_GET);
    chk("trigger", 16'(nTrig), 16'h0001);
    $display("listen test done");
  endtask

  task automatic tLocal();
    key();
    chk("remote", 16'(remoteMode), 16'h0000);
    cmd(gpd_pkg::CMD_GET);
    chk("trigger", 16'(nTrig), 16'h0001);
    cmd(LA);
    chk("remote", 16'(remoteMode), 16'h0001);
    chk("trigger", 16'(nTrig), 16'h0002);
    chk("outputOn", 16'(outputOn), 16'h0000);
    $display("local test done");
  endtask

  task automatic tLock();
    lloSeq(1'b1);
    chk("lockout", 16'(lockout), 16'h0001);
    cmd(LA);
    key();
    chk("remote", 16'(remoteMode), 16'h0001);
    cmd(gpd_pkg::CMD_GTL);
    chk("remote", 16'(remoteMode), 16'h0000);
    chk("lockout", 16'(lockout), 16'h0001);
    lloSeq(1'b0);
    chk("lockout", 16'(lockout), 16'h0000);
    chk("remote", 16'(remoteMode), 16'h0000);
    $display("lockout test done");
  endtask

  task automatic tClear();
    gpd_ctl_model_i.setRen(1'b1);
    cmd(LA);
    cmd(gpd_pkg::CMD_DCL);
    chk("devClear", 16'(nClr), 16'h0001);
    chk("outputOn", 16'(outputOn), 16'h0001);
    cmd(gpd_pkg::CMD_SDC);
    chk("devClear", 16'(nClr), 16'h0002);
    $display("clear test done");
  endtask

  task automatic tTalk();
    cmd(gpd_pkg::CMD_UNL);
    cmd(TA);
    txData  <= 8'h3C;
    txEoi   <= 1'b1;
    txValid <= 1'b1;
    chk("addressed", 16'(addressed), 16'h0001);
    gpd_ctl_model_i.rd(b, e, 20);
    txValid <= 1'b0;
    repeat (4) @(posedge clk);
    chk("talkByte", 16'(b), 16'h003C);
    chk("talkEoi", 16'(e), 16'h0001);
    chk("txTaken", 16'(nTx), 16'h0001);
    $display("talk test done");
  endtask

  task automatic tSpoll();
    svcReq <= 1'b1;
    repeat (4) @(posedge clk);
    chk("srq", 16'(busOe.srq), 16'h0001);
    cmd(gpd_pkg::CMD_SPE);
    cmd(TA);
    gpd_ctl_model_i.rd(b, e, 0);
    repeat (4) @(posedge clk);
    chk("status", 16'(b), 16'({2'b01, STAT}));
    chk("statusEoi", 16'(e), 16'h0001);
    chk("srq", 16'(busOe.srq), 16'h0000);
    chk("txTaken", 16'(nTx), 16'h0001);
    cmd(gpd_pkg::CMD_SPD);
    svcReq <= 1'b0;
    $display("serial poll test done");
  endtask

  task automatic tPpoll();
    cmd(gpd_pkg::CMD_UNT);
    cmd(LA);
    cmd(gpd_pkg::CMD_PPC);
    cmd({gpd_pkg::GRP_SEC, 5'h02});
    svcReq <= 1'b1;
    repeat (4) @(posedge clk);
    gpd_ctl_model_i.pp(b);
    chk("ppResp", 16'(b), 16'h0004);
    chk("srq", 16'(busOe.srq), 16'h0001);
    cmd(gpd_pkg::CMD_PPC);
    cmd({gpd_pkg::GRP_SEC, 5'h0A});
    gpd_ctl_model_i.pp(b);
    chk("ppResp", 16'(b), 16'h0000);
    cmd(gpd_pkg::CMD_UNL);
    chk("addressed", 16'(addressed), 16'h0000);
    $display("parallel poll test done");
  endtask

  task automatic finish_test();
    $display("compares %0d mismatches %0d", cmpCount, errorCnt);
    if (errorCnt == 0 && cmpCount > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (8) @(posedge clk);
    tReset();
    tListen();
    tLocal();
    tLock();
    tClear();
    tTalk();
    tSpoll();
    tPpoll();
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge clk);
    errorCnt++;
    finish_test();
  end
endmodule // testbench
